/* hw/thermo_i2c_pkg.sv */
package thermo_i2c_pkg;

    // ------------------------------------------------------------
    // Bus addressing and pointer layout
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_PREFIX = 4'hC;
    localparam logic [7:0] PTR_HOT_JUNCTION = 8'h00;
    localparam logic [7:0] PTR_JUNCTION_DELTA = 8'h01;
    localparam logic [7:0] PTR_COLD_JUNCTION = 8'h02;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int PTR_SEL_MSB = 5;
    localparam logic [1:0] PTR_UNUSED_BITS = 2'h0;
    localparam logic [1:0] REG_COUNT = 2'h3;

    // ------------------------------------------------------------
    // Byte framing
    // ------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int STRETCH_TIME_US = 60;
    localparam int STRETCH_CYCLES = (STRETCH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Transfer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h2,
        ST_WR_DATA = 3'h3,
        ST_WR_ACK = 3'h4,
        ST_RD_STRETCH = 3'h5,
        ST_RD_DATA = 3'h6,
        ST_RD_ACK = 3'h7
    } xfer_state_e;

endpackage

/* hw/temp_store_if.sv */
`timescale 1ns/10ps
interface temp_store_if;
    logic wr_en;
    logic [1:0] wr_idx;
    logic [15:0] wr_data;
    logic [1:0] rd_idx;
    logic [15:0] rd_data;

    modport client (
        output wr_en,
        output wr_idx,
        output wr_data,
        output rd_idx,
        input rd_data
    );

    modport store (
        input wr_en,
        input wr_idx,
        input wr_data,
        input rd_idx,
        output rd_data
    );
endinterface

/* hw/level_sync.sv */
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    // ------------------------------------------------------------
    // Two-flop synchroniser, first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stage1 <= RESET_VAL;
            sync_o <= RESET_VAL;
        end
        else
        begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

/* hw/temp_store.sv */
`timescale 1ns/10ps
module temp_store (
    input wire logic clk_i,
    input wire logic resetn_i,
    temp_store_if.store port
);
    logic [15:0] mem [0:2];
    logic [15:0] next_rd_data;
    logic [15:0] rd_data_q;

    // ------------------------------------------------------------
    // Word storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (port.wr_en && port.wr_idx < thermo_i2c_pkg::REG_COUNT)
        begin
            mem[port.wr_idx] <= port.wr_data;
        end
    end

    always_comb
    begin
        next_rd_data = thermo_i2c_pkg::WORD_RESET;
        if (port.rd_idx < thermo_i2c_pkg::REG_COUNT)
        begin
            next_rd_data = mem[port.rd_idx];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_data_q <= thermo_i2c_pkg::WORD_RESET;
        end
        else
        begin
            rd_data_q <= next_rd_data;
        end
    end

    assign port.rd_data = rd_data_q;
endmodule

/* hw/thermo_sensor_i2c_target.sv */
// Contract
// - SDA falling while SCL high is START; every transfer begins with it.
// - SDA rising while SCL high is STOP and ends the transfer.
// - START or STOP mid-byte abandons the transfer and releases SDA.
// - SDA changes only while SCL low, except START/STOP; idle bus is high.
// - Acknowledge address only if it equals prefix 1100 plus selected bits.
// - Three selectable address bits come from one of eight pin levels.
// - Last address bit: one means read, zero means write.
// - Drive acknowledge low in the ninth clock after each received byte.
// - First write byte sets pointer: 00 hot, 01 delta, 02 cold.
// - Pointer persists; each new read returns that register without rewrite.
// - During reads, hold SCL low for stretch interval after each acknowledge.
// - If host clocks early during stretch, previous byte is shifted out again.
// - Host NAKs last read byte; device then leaves SDA released.
// - Sequential read advances internal pointer after every acknowledged byte; code advances its cursor only after each acknowledged low byte.
// - STOP ends a sequential read and returns the interface to idle.
// - Multi-byte writes never advance the pointer.
// - Pointer is eight bits, upper two read as zero, lower six select.
`timescale 1ns/10ps
module thermo_sensor_i2c_target #(
    parameter int STRETCH_CYCLES = thermo_i2c_pkg::STRETCH_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] addr_level_i,
    input wire logic [15:0] hot_junction_temperature_i,
    input wire logic [15:0] junction_delta_temperature_i,
    input wire logic [15:0] cold_junction_temperature_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic scl_o,
    output logic scl_oe_o
);
    thermo_i2c_pkg::xfer_state_e state, next_state;
    logic link_bit, next_link_bit, link_tgl, next_link_tgl;
    logic scl_s, sda_s, tgl_s, scl_q, sda_q, tgl_q;
    logic [2:0] addr_s, addr_sel, next_addr_sel;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx, next_rx, tx, next_tx, ptr, next_ptr;
    logic [5:0] cursor, next_cursor;
    logic byte_lo, next_byte_lo, is_read, next_is_read;
    logic ptr_set, next_ptr_set, nak, next_nak;
    logic next_sda_oe, next_scl_oe;
    logic [15:0] stretch_cnt, next_stretch_cnt;
    logic [1:0] wr_idx, next_wr_idx;
    logic start_ev, stop_ev, scl_fall, bit_ev, addr_hit;
    logic [7:0] rd_byte, tx_rot;
    temp_store_if store_bus ();

    // ------------------------------------------------------------
    // Link domain: bit capture on SCL rising edge
    // ------------------------------------------------------------
    always_comb
    begin
        next_link_bit = sda_i;
        next_link_tgl = ~link_tgl;
    end

    always_ff @(posedge scl_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            link_bit <= 1'b1;
            link_tgl <= 1'b0;
        end
        else
        begin
            link_bit <= next_link_bit;
            link_tgl <= next_link_tgl;
        end
    end

    // ------------------------------------------------------------
    // Crossings into the system clock
    // ------------------------------------------------------------
    level_sync #(.W(2), .RESET_VAL(2'h3)) u_line_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i({scl_i, sda_i}),
        .sync_o({scl_s, sda_s})
    );

    level_sync #(.W(4), .RESET_VAL(4'h0)) u_misc_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i({link_tgl, addr_level_i}),
        .sync_o({tgl_s, addr_s})
    );

    temp_store u_store (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .port(store_bus.store)
    );

    // ------------------------------------------------------------
    // Bus events
    // ------------------------------------------------------------
    assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
    assign scl_fall = scl_q & ~scl_s;
    assign bit_ev = tgl_s ^ tgl_q;
    assign addr_hit = rx[7:1] == {thermo_i2c_pkg::ADDR_PREFIX, addr_sel};
    assign tx_rot = {tx[6:0], tx[7]};
    assign rd_byte = byte_lo ? store_bus.rd_data[7:0] : store_bus.rd_data[15:8];

    // Converter words refreshed round-robin
    assign store_bus.wr_en = 1'b1;
    assign store_bus.wr_idx = wr_idx;
    assign store_bus.wr_data = (wr_idx == 2'h0) ? hot_junction_temperature_i :
                               (wr_idx == 2'h1) ? junction_delta_temperature_i :
                               cold_junction_temperature_i;
    assign store_bus.rd_idx = (cursor < 6'(thermo_i2c_pkg::REG_COUNT)) ? cursor[1:0] : 2'h3;

    // ------------------------------------------------------------
    // Transfer state machine
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx = rx;
        next_tx = tx;
        next_ptr = ptr;
        next_cursor = cursor;
        next_byte_lo = byte_lo;
        next_is_read = is_read;
        next_ptr_set = ptr_set;
        next_nak = nak;
        next_sda_oe = sda_oe_o;
        next_scl_oe = 1'b0;
        next_stretch_cnt = stretch_cnt;
        next_addr_sel = addr_sel;
        next_wr_idx = (wr_idx == 2'h2) ? 2'h0 : wr_idx + 2'h1;
        case (state)
            thermo_i2c_pkg::ST_IDLE:
            begin
                next_sda_oe = 1'b0;
                next_addr_sel = addr_s;
            end
            thermo_i2c_pkg::ST_ADDR, thermo_i2c_pkg::ST_WR_DATA:
            begin
                if (bit_ev)
                begin
                    next_rx = {rx[6:0], link_bit};
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                if (scl_fall && bit_cnt == thermo_i2c_pkg::BYTE_BITS)
                begin
                    next_bit_cnt = 4'h0;
                    if (state == thermo_i2c_pkg::ST_WR_DATA)
                    begin
                        next_sda_oe = 1'b1;
                        next_state = thermo_i2c_pkg::ST_WR_ACK;
                        if (!ptr_set)
                        begin
                            next_ptr = {thermo_i2c_pkg::PTR_UNUSED_BITS, rx[thermo_i2c_pkg::PTR_SEL_MSB:0]};
                            next_ptr_set = 1'b1;
                        end
                    end
                    else if (addr_hit)
                    begin
                        next_sda_oe = 1'b1;
                        next_is_read = rx[0];
                        next_state = thermo_i2c_pkg::ST_ADDR_ACK;
                    end
                    else
                    begin
                        next_state = thermo_i2c_pkg::ST_IDLE;
                    end
                end
            end
            thermo_i2c_pkg::ST_ADDR_ACK, thermo_i2c_pkg::ST_WR_ACK:
            begin
                if (scl_fall)
                begin
                    next_sda_oe = 1'b0;
                    if (state == thermo_i2c_pkg::ST_ADDR_ACK && is_read)
                    begin
                        next_cursor = ptr[thermo_i2c_pkg::PTR_SEL_MSB:0];
                        next_byte_lo = 1'b0;
                        next_stretch_cnt = 16'h0000;
                        next_scl_oe = 1'b1;
                        next_state = thermo_i2c_pkg::ST_RD_STRETCH;
                    end
                    else
                    begin
                        next_ptr_set = (state == thermo_i2c_pkg::ST_WR_ACK);
                        next_state = thermo_i2c_pkg::ST_WR_DATA;
                    end
                end
            end
            thermo_i2c_pkg::ST_RD_STRETCH:
            begin
                next_scl_oe = 1'b1;
                next_stretch_cnt = stretch_cnt + 16'h0001;
                if (bit_ev)
                begin
                    // Early clock: old byte still in the shifter
                    next_scl_oe = 1'b0;
                    next_bit_cnt = 4'h1;
                    next_state = thermo_i2c_pkg::ST_RD_DATA;
                end
                else if (stretch_cnt >= 16'(STRETCH_CYCLES - 1))
                begin
                    // First bit set up a cycle before SCL is let go
                    next_scl_oe = 1'b0;
                    next_bit_cnt = 4'h0;
                    next_state = thermo_i2c_pkg::ST_RD_DATA;
                end
                else if (stretch_cnt == 16'(STRETCH_CYCLES - 2))
                begin
                    next_tx = rd_byte;
                    next_sda_oe = ~rd_byte[7];
                end
            end
            thermo_i2c_pkg::ST_RD_DATA:
            begin
                if (bit_ev)
                begin
                    next_bit_cnt = bit_cnt + 4'h1;
                end
                if (scl_fall)
                begin
                    // Rotation restores the byte after eight steps
                    next_tx = tx_rot;
                    if (bit_cnt == thermo_i2c_pkg::BYTE_BITS)
                    begin
                        next_sda_oe = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_state = thermo_i2c_pkg::ST_RD_ACK;
                    end
                    else
                    begin
                        next_sda_oe = ~tx_rot[7];
                    end
                end
            end
            thermo_i2c_pkg::ST_RD_ACK:
            begin
                next_sda_oe = 1'b0;
                if (bit_ev)
                begin
                    next_nak = link_bit;
                    next_bit_cnt = 4'h1;
                end
                if (scl_fall && bit_cnt != 4'h0)
                begin
                    next_bit_cnt = 4'h0;
                    if (!nak)
                    begin
                        next_byte_lo = ~byte_lo;
                        next_cursor = byte_lo ? cursor + 6'h01 : cursor;
                        next_stretch_cnt = 16'h0000;
                        next_scl_oe = 1'b1;
                        next_state = thermo_i2c_pkg::ST_RD_STRETCH;
                    end
                    else
                    begin
                        next_state = thermo_i2c_pkg::ST_IDLE;
                    end
                end
            end
            default:
            begin
                next_state = thermo_i2c_pkg::ST_IDLE;
            end
        endcase
        if (start_ev)
        begin
            next_state = thermo_i2c_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
        end
        else if (stop_ev)
        begin
            next_state = thermo_i2c_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
            next_scl_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= thermo_i2c_pkg::ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            tgl_q <= 1'b0;
            addr_sel <= 3'h0;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            ptr <= thermo_i2c_pkg::PTR_RESET;
            cursor <= 6'h00;
            byte_lo <= 1'b0;
            is_read <= 1'b0;
            ptr_set <= 1'b0;
            nak <= 1'b1;
            stretch_cnt <= 16'h0000;
            wr_idx <= 2'h0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            scl_q <= scl_s;
            sda_q <= sda_s;
            tgl_q <= tgl_s;
            addr_sel <= next_addr_sel;
            bit_cnt <= next_bit_cnt;
            rx <= next_rx;
            tx <= next_tx;
            ptr <= next_ptr;
            cursor <= next_cursor;
            byte_lo <= next_byte_lo;
            is_read <= next_is_read;
            ptr_set <= next_ptr_set;
            nak <= next_nak;
            stretch_cnt <= next_stretch_cnt;
            wr_idx <= next_wr_idx;
            sda_o <= 1'b0;
            sda_oe_o <= next_sda_oe;
            scl_o <= 1'b0;
            scl_oe_o <= next_scl_oe;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_start_addr;
        start_ev |=> state == thermo_i2c_pkg::ST_ADDR && bit_cnt == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("START not taken");

    property p_stop_idle;
        stop_ev && !start_ev |=> state == thermo_i2c_pkg::ST_IDLE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("STOP did not idle");

    property p_abort_release;
        (start_ev || stop_ev) |=> !sda_oe_o && !scl_oe_o;
    endproperty
    a_abort_release: assert property (p_abort_release) else $error("Lines not released");

    property p_addr_ack;
        state == thermo_i2c_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && addr_hit && !start_ev && !stop_ev
            |=> sda_oe_o && state == thermo_i2c_pkg::ST_ADDR_ACK && is_read == $past(rx[0]);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Matching address not acknowledged");

    property p_addr_silent;
        state == thermo_i2c_pkg::ST_ADDR && !addr_hit |-> ##1 !sda_oe_o;
    endproperty
    a_addr_silent: assert property (p_addr_silent) else $error("Foreign address acknowledged");

    property p_ptr_upper;
        ptr[7:6] == thermo_i2c_pkg::PTR_UNUSED_BITS;
    endproperty
    a_ptr_upper: assert property (p_ptr_upper) else $error("Pointer upper bits set");

    property p_stretch_hold;
        state == thermo_i2c_pkg::ST_RD_STRETCH && !bit_ev && !start_ev && !stop_ev
            && stretch_cnt < 16'(STRETCH_CYCLES - 1) |=> scl_oe_o;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("Stretch released early");

    property p_data_setup;
        $fell(scl_oe_o) && state == thermo_i2c_pkg::ST_RD_DATA |-> $stable(sda_oe_o);
    endproperty
    a_data_setup: assert property (p_data_setup) else $error("SDA moved as SCL was released");

    property p_nak_release;
        state == thermo_i2c_pkg::ST_RD_ACK && scl_fall && bit_cnt != 4'h0 && nak && !start_ev
            |=> !sda_oe_o ##1 !sda_oe_o;
    endproperty
    a_nak_release: assert property (p_nak_release) else $error("SDA held after NAK");

    property p_write_no_inc;
        ptr_set && state != thermo_i2c_pkg::ST_ADDR_ACK |=> $stable(ptr);
    endproperty
    a_write_no_inc: assert property (p_write_no_inc) else $error("Pointer moved on write");

    property p_seq_advance;
        state == thermo_i2c_pkg::ST_RD_ACK && scl_fall && bit_cnt != 4'h0 && !nak && byte_lo
            && !start_ev && !stop_ev |=> cursor == $past(cursor) + 6'h01;
    endproperty
    a_seq_advance: assert property (p_seq_advance) else $error("Cursor not advanced");

    c_write_ptr: cover property (state == thermo_i2c_pkg::ST_WR_ACK && ptr_set);
    c_read_byte: cover property (state == thermo_i2c_pkg::ST_RD_DATA ##1 state == thermo_i2c_pkg::ST_RD_ACK);
    c_seq_read: cover property (state == thermo_i2c_pkg::ST_RD_ACK && byte_lo && !nak && scl_fall);
    c_early_clock: cover property (state == thermo_i2c_pkg::ST_RD_STRETCH && bit_ev);
endmodule

/* tb/i2c_host_model.sv */
`timescale 1ns/10ps
module i2c_host_model (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // ------------------------------------------------------------
    // Host bus phases, quarter of a 125 ns clock
    // ------------------------------------------------------------
    localparam realtime Q = 31.25;

    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic bit_xfer(input logic b, output logic r);
        int n;
        sda_o = b;
        #Q;
        scl_o = 1'b1;
        n = 0;
        while (scl_i !== 1'b1 && n < 5000)
        begin
            #1;
            n++;
        end
        #(2*Q);
        r = sda_i;
        scl_o = 1'b0;
        #Q;
    endtask

    task automatic start();
        sda_o = 1'b1;
        #Q;
        scl_o = 1'b1;
        #(2*Q);
        sda_o = 1'b0;
        #(2*Q);
        scl_o = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sda_o = 1'b0;
        #Q;
        scl_o = 1'b1;
        #(2*Q);
        sda_o = 1'b1;
        #(8*Q);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(~ack, r);
    endtask
endmodule

/* tb/thermo_sensor_i2c_target_tb.sv */
`timescale 1ns/10ps
module thermo_sensor_i2c_target_tb;
    localparam int STRETCH = 20;
    localparam logic [15:0] HOT = 16'hA5C3;
    localparam logic [15:0] DELTA = 16'h5A3C;
    localparam logic [15:0] COLD = 16'h0F81;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] addr_level_i = 3'h5;
    logic sda_o, sda_oe_o, scl_o, scl_oe_o, host_scl, host_sda, scl, sda;
    int num_errors = 0;
    int checks = 0;
    int run = 0;
    int last_run = 0;

    assign scl = host_scl & ~scl_oe_o;
    assign sda = host_sda & ~sda_oe_o;
    always #4 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Length of the last clock stretch
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (scl_oe_o === 1'b1)
            run <= run + 1;
        else
        begin
            if (run != 0)
                last_run <= run;
            run <= 0;
        end
    end

    thermo_sensor_i2c_target #(.STRETCH_CYCLES(STRETCH)) DUT (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl),
        .sda_i(sda), .addr_level_i(addr_level_i), .hot_junction_temperature_i(HOT),
        .junction_delta_temperature_i(DELTA), .cold_junction_temperature_i(COLD), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o));
    i2c_host_model HOST (.scl_i(scl), .sda_i(sda), .scl_o(host_scl), .sda_o(host_sda));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic write_bytes(input logic [7:0] b[$]);
        logic a;
        HOST.start();
        HOST.send_byte({thermo_i2c_pkg::ADDR_PREFIX, addr_level_i, 1'b0}, a);
        check({15'h0, a}, 16'h1, "write address ack");
        foreach (b[i])
        begin
            HOST.send_byte(b[i], a);
            check({15'h0, a}, 16'h1, "data ack");
        end
        HOST.stop();
    endtask

    task automatic read_seq(input logic [15:0] exp[$]);
        logic a;
        logic [7:0] hi, lo;
        HOST.start();
        HOST.send_byte({thermo_i2c_pkg::ADDR_PREFIX, addr_level_i, 1'b1}, a);
        check({15'h0, a}, 16'h1, "read address ack");
        foreach (exp[i])
        begin
            HOST.recv_byte(1'b1, hi);
            HOST.recv_byte(i != exp.size() - 1, lo);
            check({hi, lo}, exp[i], "register word");
        end
        HOST.stop();
        check({14'h0, sda_oe_o, scl_oe_o}, 16'h0, "lines after stop");
        check({14'h0, sda_o, scl_o}, 16'h0, "driven line levels");
        check(16'(last_run >= STRETCH && last_run <= STRETCH + 1), 16'h1, "stretch length");
    endtask

    task automatic test_pointers();
        logic [15:0] w[3] = '{HOT, DELTA, COLD};
        for (int p = 0; p < 3; p++)
        begin
            write_bytes({8'(p)});
            read_seq({w[p]});
            read_seq({w[p]});
        end
        write_bytes({8'hC1});
        read_seq({DELTA});
        $display("test pointers done");
    endtask

    task automatic test_sequential();
        write_bytes({8'h00, 8'h02, 8'h01});
        read_seq({HOT, DELTA, COLD, 16'h0000});
        $display("test sequential done");
    endtask

    task automatic test_address();
        logic a;
        for (int lv = 0; lv < 8; lv++)
        begin
            @(negedge clk_i);
            addr_level_i = 3'(lv);
            repeat (8) @(negedge clk_i);
            HOST.start();
            HOST.send_byte({thermo_i2c_pkg::ADDR_PREFIX, 3'(lv) ^ 3'h1, 1'b1}, a);
            check({15'h0, a}, 16'h0, "foreign address");
            HOST.stop();
            read_seq({HOT});
        end
        $display("test address done");
    endtask

    task automatic test_abort();
        logic a, r;
        HOST.start();
        HOST.send_byte({thermo_i2c_pkg::ADDR_PREFIX, addr_level_i, 1'b0}, a);
        for (int i = 0; i < 3; i++)
        begin
            HOST.bit_xfer(1'b0, r);
        end
        HOST.start();
        repeat (8) @(negedge clk_i);
        check({14'h0, sda_oe_o, scl_oe_o}, 16'h0, "lines after mid-byte start");
        HOST.stop();
        read_seq({HOT});
        $display("test abort done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #600us;
        num_errors++;
        finish_test();
    end

    initial
    begin
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        test_pointers();
        test_sequential();
        test_abort();
        test_address();
        finish_test();
    end
endmodule
